// ### pkg/mftc_pkg.sv
package mftc_pkg;
	// Register word offsets on the plain register port.
	localparam logic [3:0] MFTC_OFF_PRESCALE = 4'h0;
	localparam logic [3:0] MFTC_OFF_COUNT_ONE = 4'h1;
	localparam logic [3:0] MFTC_OFF_COUNT_TWO = 4'h2;
	localparam logic [3:0] MFTC_OFF_RELOAD_A = 4'h3;
	localparam logic [3:0] MFTC_OFF_RELOAD_B = 4'h4;
	localparam logic [3:0] MFTC_OFF_COMPARE_A = 4'h5;
	localparam logic [3:0] MFTC_OFF_COMPARE_B = 4'h6;
	localparam logic [3:0] MFTC_OFF_CLK_SEL = 4'h7;
	localparam logic [3:0] MFTC_OFF_CONTROL = 4'h8;
	localparam logic [3:0] MFTC_OFF_IRQ_EN = 4'h9;
	localparam logic [3:0] MFTC_OFF_PENDING = 4'hA;
	// Clock select register fields.
	localparam int MFTC_SEL1_LSB = 0;
	localparam int MFTC_SEL2_LSB = 3;
	// Control register fields.
	localparam int MFTC_CTL_MODE_LSB = 0;
	localparam int MFTC_CTL_TOGGLE_EN = 3;
	localparam int MFTC_CTL_INIT_LEVEL = 4;
	localparam int MFTC_CTL_B_RISING = 5;
	localparam int MFTC_CTL_A_RISING = 6;
	localparam int MFTC_CTL_ACC_LEVEL = 7;
	localparam int MFTC_CTL_PRESET_A = 8;
	localparam int MFTC_CTL_PRESET_B = 9;
	// Pending and enable bit positions.
	localparam int MFTC_PND_A = 0;
	localparam int MFTC_PND_B = 1;
	localparam int MFTC_PND_C = 2;
	localparam int MFTC_PND_D = 3;
	// Reset values.
	localparam logic [4:0] MFTC_PRESCALE_RESET = 5'h00;
	localparam logic [15:0] MFTC_WORD_RESET = 16'h0000;
	localparam logic [15:0] MFTC_WORD_ALL_ONES = 16'hFFFF;
	localparam logic [5:0] MFTC_CLK_SEL_RESET = 6'h00;
	localparam logic [9:0] MFTC_CONTROL_RESET = 10'h001;
	localparam logic [3:0] MFTC_IRQ_EN_RESET = 4'h0;
	// Counter clock sources.
	localparam logic [2:0] MFTC_SRC_NONE = 3'h0;
	localparam logic [2:0] MFTC_SRC_PRESCALED = 3'h1;
	localparam logic [2:0] MFTC_SRC_EVENT = 3'h2;
	localparam logic [2:0] MFTC_SRC_ACCUM = 3'h3;
	localparam logic [2:0] MFTC_SRC_SLOW = 3'h4;
	// Operating modes.
	localparam logic [2:0] MFTC_MODE_PWM = 3'h1;
	localparam logic [2:0] MFTC_MODE_DUAL_CAPTURE = 3'h2;
	localparam logic [2:0] MFTC_MODE_DUAL_TIMER = 3'h3;
	localparam logic [2:0] MFTC_MODE_CAPTURE_TIMER = 3'h4;
	localparam logic [2:0] MFTC_MODE_DUAL_INDEP_CAPTURE = 3'h5;
endpackage

// ### design/mftc_timer.sv
`timescale 1ns/1ps
// Behaviour
// - Prescaler divides the core clock by its register value plus one.
// - Prescale register read/write anytime; internal down counter hidden; both cleared at reset.
// - Event clocking decrements a counter on the programmed edge of pin B.
// - Event and accumulate clocking unavailable: counter one mode 2, two mode 4, both mode 5.
// - Pulse accumulate counts prescaler pulses only while pin B sits at selected level.
// - Slow clock is synchronised; counting pauses while the core clock stops.
// - Per-counter source: none, prescaled, events, accumulate, slow; none stops and ignores captures.
// - Both 16-bit counters count down; underflow is 0000h rolling to FFFFh.
// - Mode 1: counter one is PWM base on A/B reloads; counter two system timer.
// - Mode 2: counter one captured into A on pin A, into B on pin B.
// - Mode 3: independent timers, A reloads counter one, B reloads counter two.
// - Mode 4: counter one reloads from A; B captures counter two on pin B.
// - Mode 5: A captures counter one on pin A, B captures counter two on pin B.
// - Mode 1 underflow reloads alternately from A and B, toggling pin A if enabled.
// - After reset and each mode 1 entry, first reload comes from A.
// - Restarting counter one after no clock makes the next reload come from A.
// - In mode 1 counter one starts from its present value, not a reload.
// - Software chooses the starting level of the pin A output.
// - Mode 1 reloads from A and from B set separate, separately enabled pending flags.
// - Mode 1 counter two is software loadable and interrupts after programmed events.
// - Pin A output also drives the converter trigger; pin B may be unconnected.
module mftc_timer (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	input wire logic timer_pin_a_in,
	output logic timer_pin_a_out,
	output logic timer_pin_a_oe,
	output logic converter_trigger,
	input wire logic timer_pin_b_in,
	input wire logic slow_clock,
	output logic timer_irq_one,
	output logic timer_irq_two
);

	typedef struct packed {
		logic [4:0] prescale_divisor_reg;
		logic [4:0] presc_cnt;
		logic [15:0] counter_one;
		logic [15:0] counter_two;
		logic [15:0] reload_capture_a;
		logic [15:0] reload_capture_b;
		logic [15:0] compare_value_a;
		logic [15:0] compare_value_b;
		logic [5:0] counter_clock_select;
		logic [9:0] control;
		logic [3:0] irq_en;
		logic [3:0] pending;
		logic reload_from_b;
		logic pin_level;
		logic a_s1;
		logic a_s2;
		logic a_d;
		logic b_s1;
		logic b_s2;
		logic b_d;
		logic slow_s1;
		logic slow_s2;
		logic slow_d;
		logic [15:0] rdata;
		logic pin_a_out;
		logic pin_a_oe;
		logic trigger;
		logic irq_one;
		logic irq_two;
	} mftc_state_s;

	mftc_state_s state_reg;
	mftc_state_s state_next;

	logic presc_tick;
	logic a_edge;
	logic b_edge;
	logic slow_tick;
	logic accum_gate;
	logic [2:0] mode;
	logic [2:0] sel1;
	logic [2:0] sel2;
	logic b_free1;
	logic b_free2;
	logic tick1;
	logic tick2;
	logic under1;
	logic under2;
	logic run1;
	logic run2;
	logic toggles;
	logic [3:0] pend_set;
	logic [3:0] pend_clr;

	// Pick the clock pulse of one counter from its selected source.
	function automatic logic mftc_pick(input logic [2:0] sel, input logic b_free, input logic p,
		input logic e, input logic acc, input logic s);
		logic t;
		t = 1'b0;
		case (sel)
			mftc_pkg::MFTC_SRC_PRESCALED: t = p;
			mftc_pkg::MFTC_SRC_EVENT: t = e & b_free;
			mftc_pkg::MFTC_SRC_ACCUM: t = acc & b_free;
			mftc_pkg::MFTC_SRC_SLOW: t = s;
			default: t = 1'b0;
		endcase
		return t;
	endfunction

	// Clock sources, edges and per-counter ticks.
	always_comb begin
		mode = state_reg.control[mftc_pkg::MFTC_CTL_MODE_LSB +: 3];
		sel1 = state_reg.counter_clock_select[mftc_pkg::MFTC_SEL1_LSB +: 3];
		sel2 = state_reg.counter_clock_select[mftc_pkg::MFTC_SEL2_LSB +: 3];
		presc_tick = (state_reg.presc_cnt == 5'h00);
		// Pin B meets the hold time of one core clock, so no edge is missed.
		if (state_reg.control[mftc_pkg::MFTC_CTL_B_RISING]) begin
			b_edge = state_reg.b_s2 & ~state_reg.b_d;
		end else begin
			b_edge = ~state_reg.b_s2 & state_reg.b_d;
		end
		if (state_reg.control[mftc_pkg::MFTC_CTL_A_RISING]) begin
			a_edge = state_reg.a_s2 & ~state_reg.a_d;
		end else begin
			a_edge = ~state_reg.a_s2 & state_reg.a_d;
		end
		slow_tick = state_reg.slow_s2 & ~state_reg.slow_d;
		accum_gate = presc_tick
			& (state_reg.b_s2 == state_reg.control[mftc_pkg::MFTC_CTL_ACC_LEVEL]);
		b_free1 = (mode != mftc_pkg::MFTC_MODE_DUAL_CAPTURE)
			&& (mode != mftc_pkg::MFTC_MODE_DUAL_INDEP_CAPTURE);
		b_free2 = (mode != mftc_pkg::MFTC_MODE_CAPTURE_TIMER)
			&& (mode != mftc_pkg::MFTC_MODE_DUAL_INDEP_CAPTURE);
		tick1 = mftc_pick(sel1, b_free1, presc_tick, b_edge, accum_gate, slow_tick);
		tick2 = mftc_pick(sel2, b_free2, presc_tick, b_edge, accum_gate, slow_tick);
		run1 = (sel1 != mftc_pkg::MFTC_SRC_NONE);
		run2 = (sel2 != mftc_pkg::MFTC_SRC_NONE);
		under1 = tick1 && (state_reg.counter_one == mftc_pkg::MFTC_WORD_RESET);
		under2 = tick2 && (state_reg.counter_two == mftc_pkg::MFTC_WORD_RESET);
		toggles = (mode == mftc_pkg::MFTC_MODE_PWM) || (mode == mftc_pkg::MFTC_MODE_DUAL_TIMER)
			|| (mode == mftc_pkg::MFTC_MODE_CAPTURE_TIMER);
	end

	// Next state: prescaler, counters, captures, reloads, pending flags and the register port.
	always_comb begin
		state_next = state_reg;
		pend_set = 4'h0;
		pend_clr = 4'h0;
		// Synchronisers for pins A, B and the slow clock.
		state_next.a_s1 = timer_pin_a_in;
		state_next.a_s2 = state_reg.a_s1;
		state_next.a_d = state_reg.a_s2;
		state_next.b_s1 = timer_pin_b_in;
		state_next.b_s2 = state_reg.b_s1;
		state_next.b_d = state_reg.b_s2;
		state_next.slow_s1 = slow_clock;
		state_next.slow_s2 = state_reg.slow_s1;
		state_next.slow_d = state_reg.slow_s2;
		// Prescaler reloads the divisor on each output pulse.
		if (presc_tick) begin
			state_next.presc_cnt = state_reg.prescale_divisor_reg;
		end else begin
			state_next.presc_cnt = state_reg.presc_cnt - 5'h01;
		end
		// Plain decrement; the cases below replace the value on underflow or capture.
		if (tick1) begin
			state_next.counter_one = state_reg.counter_one - 16'h0001;
		end
		if (tick2) begin
			state_next.counter_two = state_reg.counter_two - 16'h0001;
		end
		case (mode)
			mftc_pkg::MFTC_MODE_PWM: begin
				if (under1) begin
					if (state_reg.reload_from_b) begin
						state_next.counter_one = state_reg.reload_capture_b;
						pend_set[mftc_pkg::MFTC_PND_B] = 1'b1;
					end else begin
						state_next.counter_one = state_reg.reload_capture_a;
						pend_set[mftc_pkg::MFTC_PND_A] = 1'b1;
					end
					state_next.reload_from_b = ~state_reg.reload_from_b;
				end
				if (under2) begin
					pend_set[mftc_pkg::MFTC_PND_D] = 1'b1;
				end
			end
			mftc_pkg::MFTC_MODE_DUAL_CAPTURE: begin
				if (run1 && a_edge) begin
					state_next.reload_capture_a = state_reg.counter_one;
					pend_set[mftc_pkg::MFTC_PND_A] = 1'b1;
					if (state_reg.control[mftc_pkg::MFTC_CTL_PRESET_A]) begin
						state_next.counter_one = mftc_pkg::MFTC_WORD_ALL_ONES;
					end
				end
				if (run1 && b_edge) begin
					state_next.reload_capture_b = state_reg.counter_one;
					pend_set[mftc_pkg::MFTC_PND_B] = 1'b1;
					if (state_reg.control[mftc_pkg::MFTC_CTL_PRESET_B]) begin
						state_next.counter_one = mftc_pkg::MFTC_WORD_ALL_ONES;
					end
				end
				pend_set[mftc_pkg::MFTC_PND_C] = under1;
				pend_set[mftc_pkg::MFTC_PND_D] = under2;
			end
			mftc_pkg::MFTC_MODE_DUAL_TIMER: begin
				if (under1) begin
					state_next.counter_one = state_reg.reload_capture_a;
				end
				if (under2) begin
					state_next.counter_two = state_reg.reload_capture_b;
				end
				pend_set[mftc_pkg::MFTC_PND_A] = under1;
				pend_set[mftc_pkg::MFTC_PND_D] = under2;
			end
			mftc_pkg::MFTC_MODE_CAPTURE_TIMER: begin
				if (under1) begin
					state_next.counter_one = state_reg.reload_capture_a;
				end
				if (run2 && b_edge) begin
					state_next.reload_capture_b = state_reg.counter_two;
					pend_set[mftc_pkg::MFTC_PND_B] = 1'b1;
					if (state_reg.control[mftc_pkg::MFTC_CTL_PRESET_B]) begin
						state_next.counter_two = mftc_pkg::MFTC_WORD_ALL_ONES;
					end
				end
				pend_set[mftc_pkg::MFTC_PND_A] = under1;
				pend_set[mftc_pkg::MFTC_PND_D] = under2;
			end
			mftc_pkg::MFTC_MODE_DUAL_INDEP_CAPTURE: begin
				if (run1 && a_edge) begin
					state_next.reload_capture_a = state_reg.counter_one;
					pend_set[mftc_pkg::MFTC_PND_A] = 1'b1;
					if (state_reg.control[mftc_pkg::MFTC_CTL_PRESET_A]) begin
						state_next.counter_one = mftc_pkg::MFTC_WORD_ALL_ONES;
					end
				end
				if (run2 && b_edge) begin
					state_next.reload_capture_b = state_reg.counter_two;
					pend_set[mftc_pkg::MFTC_PND_B] = 1'b1;
					if (state_reg.control[mftc_pkg::MFTC_CTL_PRESET_B]) begin
						state_next.counter_two = mftc_pkg::MFTC_WORD_ALL_ONES;
					end
				end
				pend_set[mftc_pkg::MFTC_PND_C] = under1;
				pend_set[mftc_pkg::MFTC_PND_D] = under2;
			end
			default: begin
				pend_set = 4'h0;
			end
		endcase
		// Outside mode 1, or with counter one stopped, the next reload is from A.
		if ((mode != mftc_pkg::MFTC_MODE_PWM) || !run1) begin
			state_next.reload_from_b = 1'b0;
		end
		// Pin A level: preset while toggling is off, toggles on counter one underflow.
		if (!state_reg.control[mftc_pkg::MFTC_CTL_TOGGLE_EN] || !toggles) begin
			state_next.pin_level = state_reg.control[mftc_pkg::MFTC_CTL_INIT_LEVEL];
		end else if (under1) begin
			state_next.pin_level = ~state_reg.pin_level;
		end
		// Register writes; a software counter load overrides the count.
		if (reg_write) begin
			if (reg_addr == mftc_pkg::MFTC_OFF_PRESCALE) begin
				state_next.prescale_divisor_reg = reg_wdata[4:0];
			end else if (reg_addr == mftc_pkg::MFTC_OFF_COUNT_ONE) begin
				state_next.counter_one = reg_wdata;
			end else if (reg_addr == mftc_pkg::MFTC_OFF_COUNT_TWO) begin
				state_next.counter_two = reg_wdata;
			end else if (reg_addr == mftc_pkg::MFTC_OFF_RELOAD_A) begin
				state_next.reload_capture_a = reg_wdata;
			end else if (reg_addr == mftc_pkg::MFTC_OFF_RELOAD_B) begin
				state_next.reload_capture_b = reg_wdata;
			end else if (reg_addr == mftc_pkg::MFTC_OFF_COMPARE_A) begin
				state_next.compare_value_a = reg_wdata;
			end else if (reg_addr == mftc_pkg::MFTC_OFF_COMPARE_B) begin
				state_next.compare_value_b = reg_wdata;
			end else if (reg_addr == mftc_pkg::MFTC_OFF_CLK_SEL) begin
				state_next.counter_clock_select = reg_wdata[5:0];
			end else if (reg_addr == mftc_pkg::MFTC_OFF_CONTROL) begin
				state_next.control = reg_wdata[9:0];
			end else if (reg_addr == mftc_pkg::MFTC_OFF_IRQ_EN) begin
				state_next.irq_en = reg_wdata[3:0];
			end else if (reg_addr == mftc_pkg::MFTC_OFF_PENDING) begin
				pend_clr = reg_wdata[3:0];
			end
		end
		// A set in the clear cycle survives.
		state_next.pending = (state_reg.pending & ~pend_clr) | pend_set;
		// Read data stands in the cycle after the read strobe only.
		state_next.rdata = 16'h0000;
		if (reg_read) begin
			if (reg_addr == mftc_pkg::MFTC_OFF_PRESCALE) begin
				state_next.rdata = {11'h000, state_reg.prescale_divisor_reg};
			end else if (reg_addr == mftc_pkg::MFTC_OFF_COUNT_ONE) begin
				state_next.rdata = state_reg.counter_one;
			end else if (reg_addr == mftc_pkg::MFTC_OFF_COUNT_TWO) begin
				state_next.rdata = state_reg.counter_two;
			end else if (reg_addr == mftc_pkg::MFTC_OFF_RELOAD_A) begin
				state_next.rdata = state_reg.reload_capture_a;
			end else if (reg_addr == mftc_pkg::MFTC_OFF_RELOAD_B) begin
				state_next.rdata = state_reg.reload_capture_b;
			end else if (reg_addr == mftc_pkg::MFTC_OFF_COMPARE_A) begin
				state_next.rdata = state_reg.compare_value_a;
			end else if (reg_addr == mftc_pkg::MFTC_OFF_COMPARE_B) begin
				state_next.rdata = state_reg.compare_value_b;
			end else if (reg_addr == mftc_pkg::MFTC_OFF_CLK_SEL) begin
				state_next.rdata = {10'h000, state_reg.counter_clock_select};
			end else if (reg_addr == mftc_pkg::MFTC_OFF_CONTROL) begin
				state_next.rdata = {6'h00, state_reg.control};
			end else if (reg_addr == mftc_pkg::MFTC_OFF_IRQ_EN) begin
				state_next.rdata = {12'h000, state_reg.irq_en};
			end else if (reg_addr == mftc_pkg::MFTC_OFF_PENDING) begin
				state_next.rdata = {12'h000, state_reg.pending};
			end
		end
		// Registered outputs, following the state one cycle behind.
		state_next.pin_a_out = state_reg.pin_level;
		state_next.trigger = state_reg.pin_level;
		state_next.pin_a_oe = toggles;
		state_next.irq_one = |(state_reg.pending[2:0] & state_reg.irq_en[2:0]);
		state_next.irq_two = state_reg.pending[mftc_pkg::MFTC_PND_D]
			& state_reg.irq_en[mftc_pkg::MFTC_PND_D];
	end

	// State register with constant reset values.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= '0;
			state_reg.prescale_divisor_reg <= mftc_pkg::MFTC_PRESCALE_RESET;
			state_reg.presc_cnt <= mftc_pkg::MFTC_PRESCALE_RESET;
			state_reg.counter_clock_select <= mftc_pkg::MFTC_CLK_SEL_RESET;
			state_reg.control <= mftc_pkg::MFTC_CONTROL_RESET;
			state_reg.irq_en <= mftc_pkg::MFTC_IRQ_EN_RESET;
			state_reg.reload_from_b <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata = state_reg.rdata;
	assign timer_pin_a_out = state_reg.pin_a_out;
	assign timer_pin_a_oe = state_reg.pin_a_oe;
	assign converter_trigger = state_reg.trigger;
	assign timer_irq_one = state_reg.irq_one;
	assign timer_irq_two = state_reg.irq_two;

endmodule // mftc_timer

// ### testbench/mftc_timer_assertions.sv
`timescale 1ns/1ps
module mftc_timer_checker (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] reg_rdata,
	input wire logic timer_pin_a_out,
	input wire logic timer_pin_a_oe,
	input wire logic converter_trigger,
	input wire logic timer_irq_one,
	input wire logic timer_irq_two
);
	logic [9:0] ctl_reg;
	logic [3:0] en_reg;
	logic [1:0] age_reg;
	logic drive_mode;
	// Shadows control and enables; age counts settled cycles since either was written.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_reg <= mftc_pkg::MFTC_CONTROL_RESET;
			en_reg <= mftc_pkg::MFTC_IRQ_EN_RESET;
			age_reg <= 2'h0;
		end else if (reg_write && reg_addr == mftc_pkg::MFTC_OFF_CONTROL) begin
			ctl_reg <= reg_wdata[9:0];
			age_reg <= 2'h0;
		end else if (reg_write && reg_addr == mftc_pkg::MFTC_OFF_IRQ_EN) begin
			en_reg <= reg_wdata[3:0];
			age_reg <= 2'h0;
		end else if (age_reg != 2'h3) begin
			age_reg <= age_reg + 2'h1;
		end
	end
	// Modes in which pin A is an output.
	assign drive_mode = ctl_reg[2:0] == 3'h1 || ctl_reg[2:0] == 3'h3 || ctl_reg[2:0] == 3'h4;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside the answer cycle");
	a_prescale_width: assert property (
		reg_read && reg_addr == 4'h0 |=> reg_rdata[15:5] == 11'h000)
		else $error("prescale read wider than five bits");
	a_pending_width: assert property (
		reg_read && reg_addr == 4'hA |=> reg_rdata[15:4] == 12'h000)
		else $error("pending read wider than four bits");
	a_trigger_copy: assert property (converter_trigger == timer_pin_a_out)
		else $error("converter trigger differs from pin A");
	a_oe_mode: assert property (age_reg == 2'h3 |-> timer_pin_a_oe == drive_mode)
		else $error("pin A drive enable wrong for mode");
	a_pin_level: assert property (
		age_reg == 2'h3 && !ctl_reg[3] |-> timer_pin_a_out == ctl_reg[4])
		else $error("pin A not at initial level");
	a_irq_one_off: assert property (
		age_reg == 2'h3 && en_reg[2:0] == 3'h0 |-> !timer_irq_one)
		else $error("interrupt one without enable");
	a_irq_two_off: assert property (
		age_reg == 2'h3 && !en_reg[3] ##1 !en_reg[3] |-> !timer_irq_two)
		else $error("interrupt two without enable");
	c_irq_one: cover property ($rose(timer_irq_one));
	c_irq_two: cover property ($rose(timer_irq_two));
	c_toggle: cover property (ctl_reg[3] && $changed(timer_pin_a_out));
endmodule // mftc_timer_checker
bind mftc_timer mftc_timer_checker chk_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.timer_pin_a_out(timer_pin_a_out), .timer_pin_a_oe(timer_pin_a_oe),
	.converter_trigger(converter_trigger), .timer_irq_one(timer_irq_one),
	.timer_irq_two(timer_irq_two));

// ### testbench/mftc_pin_partner.sv
`timescale 1ns/1ps
module mftc_pin_partner (
	input wire logic clk,
	output logic pin_a,
	output logic pin_b,
	output logic slow_clock
);
	// Pin A is a capture input in modes 2 and 5 run here, but no capture is tested, so it rests low.
	initial begin
		pin_a = 1'b0;
		pin_b = 1'b0;
		slow_clock = 1'b0;
		forever #15259 slow_clock = ~slow_clock;
	end
	// Flips pin B n times, each level held three core clocks, then lets the sync settle.
	task automatic flip(input int n);
		repeat (n) begin
			@(posedge clk);
			pin_b <= ~pin_b;
			repeat (2) @(posedge clk);
		end
		repeat (3) @(posedge clk);
	endtask
endmodule // mftc_pin_partner

// ### testbench/tb_mftc_timer.sv
`timescale 1ns/1ps
module tb_mftc_timer;
	logic clk, arst_n, reg_write, reg_read, pin_a_in, pin_b_in, slow_clock;
	logic pin_a_out, pin_a_oe, trig, irq_one, irq_two;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, v;
	logic [31:0] seed;
	int n_mismatch, cmp_count, p, ra, rb, k, t;
	int md[4] = '{2, 4, 5, 5};
	logic [2:0] sr[3] = '{3'h2, 3'h3, 3'h0};
	mftc_timer dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.timer_pin_a_in(pin_a_in), .timer_pin_a_out(pin_a_out), .timer_pin_a_oe(pin_a_oe),
		.converter_trigger(trig), .timer_pin_b_in(pin_b_in), .slow_clock(slow_clock),
		.timer_irq_one(irq_one), .timer_irq_two(irq_two));
	mftc_pin_partner partner_u (.clk(clk), .pin_a(pin_a_in), .pin_b(pin_b_in),
		.slow_clock(slow_clock));
	// Core clock.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Draws a value below m from the shift register.
	function automatic int rnd(input int m);
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return int'(seed[15:0]) % m;
	endfunction
	// Cycles between two pin A toggles when counter one counts down from r.
	function automatic int period(input int r);
		return (r + 1) * (p + 1);
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask
	// Cycles until pin A next changes level, bounded.
	task automatic gap(output int n);
		logic l;
		l = pin_a_out;
		n = 0;
		while (pin_a_out === l && n < 2000) begin
			@(negedge clk);
			n++;
		end
	endtask
	// Restarts counter one from k and times three underflows: reloads go A, B, A.
	task automatic pwm_run();
		wr(4'h7, 16'h0000);
		wr(4'h1, 16'(k));
		wr(4'h7, 16'(mftc_pkg::MFTC_SRC_PRESCALED));
		@(negedge clk);
		gap(t);
		check(16'(t >= k * (p + 1) + 2 && t <= period(k) + 1), 16'h0001);
		gap(t);
		check(16'(t), 16'(period(ra)));
		gap(t);
		check(16'(t), 16'(period(rb)));
		rd(4'hA, v);
		check(v & 16'h0003, 16'h0003);
		check({15'h0, irq_one}, 16'h0001);
		wr(4'hA, 16'h000F);
		repeat (2) @(negedge clk);
		check({15'h0, irq_one}, 16'h0000);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Watchdog against a hang.
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end
	// Main sequence.
	initial begin
		seed = 32'h43e7_7436;
		n_mismatch = 0;
		cmp_count = 0;
		arst_n = 1'b0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		rd(4'h0, v);
		check(v, 16'h0000);
		rd(4'h8, v);
		check(v, 16'(mftc_pkg::MFTC_CONTROL_RESET));
		rd(4'hC, v);
		check(v, 16'h0000);
		p = rnd(4);
		ra = 8 + rnd(8);
		rb = ra + 1 + rnd(4);
		k = 1 + rnd(6);
		wr(4'h0, 16'hFFE0 | 16'(p));
		rd(4'h0, v);
		check(v, 16'(p));
		wr(4'h3, 16'(ra));
		wr(4'h4, 16'(rb));
		wr(4'h9, 16'h000B);
		wr(4'h8, 16'h0011);
		repeat (3) @(negedge clk);
		check({15'h0, pin_a_out}, 16'h0001);
		wr(4'h8, 16'h0019);
		pwm_run();
		pwm_run();
		// Pin B events on counter two, rising then falling; k plus one edges underflow it.
		for (int pol = 1; pol >= 0; pol--) begin
			k = 1 + rnd(5);
			wr(4'h8, 16'h0001 | 16'(pol << mftc_pkg::MFTC_CTL_B_RISING));
			wr(4'h2, 16'(k));
			wr(4'h7, 16'(mftc_pkg::MFTC_SRC_EVENT) << mftc_pkg::MFTC_SEL2_LSB);
			partner_u.flip(2 * k + 1);
			rd(4'h2, v);
			check(v, 16'hFFFF);
			check({15'h0, irq_two}, 16'h0001);
			wr(4'hA, 16'h000F);
		end
		// Refused or absent sources leave the counter still.
		for (int i = 0; i < 12; i++) begin
			wr(4'h8, 16'(md[i % 4]));
			wr(4'(1 + i % 2), 16'h0100);
			wr(4'h7, 16'(sr[i / 4]) << (i % 2 == 0 ? 0 : 3));
			partner_u.flip(4);
			rd(4'(1 + i % 2), v);
			check(v, 16'h0100);
		end
		// Accumulate counts every core clock only while pin B is high.
		wr(4'h0, 16'h0000);
		wr(4'h8, 16'h0081);
		wr(4'h2, 16'h0100);
		wr(4'h7, 16'(mftc_pkg::MFTC_SRC_ACCUM) << mftc_pkg::MFTC_SEL2_LSB);
		repeat (20) @(posedge clk);
		rd(4'h2, v);
		check(v, 16'h0100);
		partner_u.flip(1);
		repeat (20) @(posedge clk);
		partner_u.flip(1);
		rd(4'h2, v);
		check(16'(v >= 16'h00E2 && v <= 16'h00EA), 16'h0001);
		// Slow clock: about three and a third periods in 2000 core clocks.
		wr(4'h2, 16'h0100);
		wr(4'h7, 16'(mftc_pkg::MFTC_SRC_SLOW) << mftc_pkg::MFTC_SEL2_LSB);
		repeat (2000) @(posedge clk);
		rd(4'h2, v);
		check(16'(v >= 16'h00FB && v <= 16'h00FD), 16'h0001);
		give_verdict();
	end
endmodule // tb_mftc_timer
